// ### pkg/sdec_cfg.svh
// register map, field positions and reset values of the drop event capture block
`ifndef SDEC_CFG_SVH
`define SDEC_CFG_SVH

// bus geometry
`define SDEC_ADDR_W      18
`define SDEC_DATA_W      32

// register indices; byte address is four times the index
`define SDEC_IMR_IDX     16'h1C20
`define SDEC_IPR_IDX     16'h1C21
`define SDEC_EVS_IDX     16'h1C22
`define SDEC_EVM_IDX     16'h1C23
`define SDEC_IDX_LSB     2'h0

// mask register field and reset
`define SDEC_IMR_BIT     0
`define SDEC_IMR_RST     1'h1

// pending register fields
`define SDEC_A_VALID_BIT 0
`define SDEC_A_PORT_LSB  1
`define SDEC_A_RSN_LSB   3
`define SDEC_B_PEND_BIT  7
`define SDEC_B_PORT_LSB  8
`define SDEC_B_RSN_LSB   10
`define SDEC_IPR_USED_W  14

// event status / event mask layout
`define SDEC_EVS_W       3
`define SDEC_EVS_RST     3'h0
`define SDEC_EVM_RST     3'h7

// reserved source port code
`define SDEC_PORT_RSVD   2'h3

`endif

// ### pkg/sdec_pkg.sv
// types shared by the drop event capture block
package sdec_pkg;

  // drop reason encoding, identical for both slots
  typedef enum logic [3:0] {
    SDEC_RSN_BCAST_LEVEL = 4'h0,  // unknown/broadcast dest, broadcast level exceeded
    SDEC_RSN_RED         = 4'h1,  // red packet with red drop enabled
    SDEC_RSN_NO_BUF      = 4'h2,  // no free buffer
    SDEC_RSN_NO_DESC     = 4'h3,  // no memory descriptor
    SDEC_RSN_NO_DEST     = 4'h4,  // unknown/broadcast dest, no valid port
    SDEC_RSN_RX_ERR      = 4'h5,  // receive error, longer than 64 bytes
    SDEC_RSN_DROP_LEVEL  = 4'h6,  // buffer drop level exceeded
    SDEC_RSN_YELLOW      = 4'h9   // yellow packet randomly discarded
  } sdec_reason_e;

  // source port encoding
  typedef enum logic [1:0] {
    SDEC_PORT0 = 2'h0,
    SDEC_PORT1 = 2'h1,
    SDEC_PORT2 = 2'h2
  } sdec_port_e;

endpackage

// ### pkg/sdec_slot_if.sv
// signals between the capture controller and one record slot
`timescale 1ns/1ps
interface sdec_slot_if;
  logic       load;        // store a new record
  logic       clear;       // clear-on-read
  logic [3:0] in_reason;   // reason to store
  logic [1:0] in_port;     // port to store
  logic       valid;       // slot holds a record
  logic [3:0] rec_reason;  // stored reason
  logic [1:0] rec_port;    // stored port

  modport ctrl (output load, output clear, output in_reason, output in_port,
                input valid, input rec_reason, input rec_port);
  modport slot (input load, input clear, input in_reason, input in_port,
                output valid, output rec_reason, output rec_port);
endinterface

// ### logic/sdec_slot.sv
// one drop record slot: valid flag, reason and port, cleared on read
`timescale 1ns/1ps
module sdec_slot (
  input wire logic   pclk,
  input wire logic   presetn,
  sdec_slot_if.slot  sif
);

  logic       valid_q,  valid_d;   // record present
  logic [3:0] reason_q, reason_d;  // recorded reason
  logic [1:0] port_q,   port_d;    // recorded port

  // next record: a new load wins over the clear
  always_comb begin
    valid_d  = valid_q;
    reason_d = reason_q;
    port_d   = port_q;
    if (sif.load) begin
      valid_d  = 1'b1;
      reason_d = sif.in_reason;
      port_d   = sif.in_port;
    end else if (sif.clear) begin
      valid_d  = 1'b0;
      reason_d = 4'h0;
      port_d   = 2'h0;
    end
  end

  // record registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_q  <= 1'b0;
      reason_q <= 4'h0;
      port_q   <= 2'h0;
    end else begin
      valid_q  <= valid_d;
      reason_q <= reason_d;
      port_q   <= port_d;
    end
  end

  assign sif.valid      = valid_q;
  assign sif.rec_reason = reason_q;
  assign sif.rec_port   = port_q;

endmodule

// ### logic/sdec_capture.sv
// drop event capture: two record slots, mask, event status and APB registers
`timescale 1ns/1ps
`include "sdec_cfg.svh"
module sdec_capture (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [`SDEC_ADDR_W-1:0]  paddr,
  input  wire logic [`SDEC_DATA_W-1:0]  pwdata,
  output logic      [`SDEC_DATA_W-1:0]  prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     drop_valid,
  input  wire logic [3:0]               drop_reason,
  input  wire logic [1:0]               drop_port,
  output logic                          irq
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  localparam logic [`SDEC_ADDR_W-1:0] IMR_ADDR = {`SDEC_IMR_IDX, `SDEC_IDX_LSB};  // mask
  localparam logic [`SDEC_ADDR_W-1:0] IPR_ADDR = {`SDEC_IPR_IDX, `SDEC_IDX_LSB};  // pending
  localparam logic [`SDEC_ADDR_W-1:0] EVS_ADDR = {`SDEC_EVS_IDX, `SDEC_IDX_LSB};  // event status
  localparam logic [`SDEC_ADDR_W-1:0] EVM_ADDR = {`SDEC_EVM_IDX, `SDEC_IDX_LSB};  // event mask

  logic setup_rd;   // read setup cycle
  logic acc_wr;     // write access cycle
  logic sel_imr;    // decode hits
  logic sel_ipr;
  logic sel_evs;
  logic sel_evm;
  logic ipr_clr;    // clear-on-read strobe

  assign setup_rd = psel & ~penable & ~pwrite;
  assign acc_wr   = psel & penable & pwrite;
  assign sel_imr  = (paddr == IMR_ADDR);
  assign sel_ipr  = (paddr == IPR_ADDR);
  assign sel_evs  = (paddr == EVS_ADDR);
  assign sel_evm  = (paddr == EVM_ADDR);
  // read data is sampled at setup, so the clear acts there too
  assign ipr_clr  = setup_rd & sel_ipr;

  // zero wait states
  assign pready   = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // record slots

  sdec_slot_if a_if ();  // slot A
  sdec_slot_if b_if ();  // slot B

  sdec_slot u_slot_a (
    .pclk    (pclk),
    .presetn (presetn),
    .sif     (a_if.slot)
  );

  sdec_slot u_slot_b (
    .pclk    (pclk),
    .presetn (presetn),
    .sif     (b_if.slot)
  );

  logic ev_ok;   // event with a legal port
  logic a_free;  // slot A can take the event
  logic b_free;  // slot B can take the event
  logic load_a;
  logic load_b;
  logic lost;    // both slots busy

  // reserved port code is never recorded
  assign ev_ok  = drop_valid & (drop_port != `SDEC_PORT_RSVD);
  // a slot being cleared this cycle counts as free: the set wins
  assign a_free = ~a_if.valid | ipr_clr;
  assign b_free = ~b_if.valid | ipr_clr;
  // allocation: A first, then B, else drop
  assign load_a = ev_ok & a_free;
  assign load_b = ev_ok & ~a_free & b_free;
  assign lost   = ev_ok & ~a_free & ~b_free;

  assign a_if.load      = load_a;
  assign a_if.clear     = ipr_clr;
  // reason codes are stored as given, reserved ones included
  assign a_if.in_reason = drop_reason;
  assign a_if.in_port   = drop_port;
  assign b_if.load      = load_b;
  assign b_if.clear     = ipr_clr;
  assign b_if.in_reason = drop_reason;
  assign b_if.in_port   = drop_port;

  // pending register image
  logic [`SDEC_DATA_W-1:0] ipr_word;
  always_comb begin
    ipr_word = '0;
    ipr_word[`SDEC_A_VALID_BIT]                  = a_if.valid;
    ipr_word[`SDEC_A_PORT_LSB +: 2]              = a_if.rec_port;
    ipr_word[`SDEC_A_RSN_LSB +: 4]               = a_if.rec_reason;
    ipr_word[`SDEC_B_PEND_BIT]                   = b_if.valid;
    ipr_word[`SDEC_B_PORT_LSB +: 2]              = b_if.rec_port;
    ipr_word[`SDEC_B_RSN_LSB +: 4]               = b_if.rec_reason;
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers

  logic                    imr_q, imr_d;          // interrupt mask
  logic [`SDEC_EVS_W-1:0]  evs_q, evs_d;          // sticky events
  logic [`SDEC_EVS_W-1:0]  evm_q, evm_d;          // event mask
  logic [`SDEC_DATA_W-1:0] prdata_q, prdata_d;    // read data
  logic                    slverr_q, slverr_d;    // unmapped access

  // next values of the register file
  always_comb begin
    imr_d    = imr_q;
    evm_d    = evm_q;
    evs_d    = evs_q;
    prdata_d = prdata_q;
    slverr_d = slverr_q;
    // writes land at the access edge
    if (acc_wr && sel_imr) begin
      imr_d = pwdata[`SDEC_IMR_BIT];
    end
    if (acc_wr && sel_evm) begin
      evm_d = pwdata[`SDEC_EVS_W-1:0];
    end
    if (acc_wr && sel_evs) begin
      evs_d = evs_q & ~pwdata[`SDEC_EVS_W-1:0];  // write one to clear
    end
    // new events win over a clear in the same cycle
    evs_d = evs_d | {lost, load_b, load_a};
    // reads and errors are captured at setup
    if (psel && !penable) begin
      prdata_d = '0;
      slverr_d = 1'b0;
      if (sel_imr) begin
        prdata_d[`SDEC_IMR_BIT] = imr_q;
      end else if (sel_ipr) begin
        prdata_d = pwrite ? '0 : ipr_word;
      end else if (sel_evs) begin
        prdata_d[`SDEC_EVS_W-1:0] = evs_q;
      end else if (sel_evm) begin
        prdata_d[`SDEC_EVS_W-1:0] = evm_q;
      end else begin
        slverr_d = 1'b1;  // unmapped address
      end
    end
  end

  // register file flops; mask comes up set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imr_q    <= `SDEC_IMR_RST;
      evs_q    <= `SDEC_EVS_RST;
      evm_q    <= `SDEC_EVM_RST;
      prdata_q <= '0;
      slverr_q <= 1'b0;
    end else begin
      imr_q    <= imr_d;
      evs_q    <= evs_d;
      evm_q    <= evm_d;
      prdata_q <= prdata_d;
      slverr_q <= slverr_d;
    end
  end

  assign prdata  = prdata_q;
  assign pslverr = slverr_q & psel & penable;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt output

  logic irq_src;  // any unmasked cause
  // the mask only touches this path, records run on regardless
  assign irq_src = a_if.valid | b_if.valid | (|(evs_q & ~evm_q));
  assign irq     = ~imr_q & irq_src;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_ev_to_a;
    ev_ok && !a_if.valid && !ipr_clr;
  endsequence

  sequence s_ev_to_b;
    ev_ok && a_if.valid && !b_if.valid && !ipr_clr;
  endsequence

  sequence s_read_setup;
    ipr_clr && !drop_valid;
  endsequence

  property p_mask_blocks;
    imr_q |-> !irq;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) else $error("irq high while masked");

  property p_mask_keeps_record;
    s_ev_to_a ##0 (imr_q && !(acc_wr && sel_imr)) |=> a_if.valid && !irq;
  endproperty
  a_mask_keeps_record: assert property (p_mask_keeps_record) else $error("masked event not recorded");

  property p_fill_a;
    s_ev_to_a |=> a_if.valid && a_if.rec_reason == $past(drop_reason) && a_if.rec_port == $past(drop_port);
  endproperty
  a_fill_a: assert property (p_fill_a) else $error("slot A not filled");

  property p_fill_b;
    s_ev_to_b |=> b_if.valid && a_if.valid && b_if.rec_port == $past(drop_port)
                  && b_if.rec_reason == $past(drop_reason);
  endproperty
  a_fill_b: assert property (p_fill_b) else $error("slot B not filled");

  property p_discard;
    (ev_ok && a_if.valid && b_if.valid && !ipr_clr) |=> ipr_word == $past(ipr_word) && evs_q[2];
  endproperty
  a_discard: assert property (p_discard) else $error("full slots changed");

  property p_read_clears;
    s_read_setup |=> ipr_word == '0;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("pending not cleared by read");

  property p_read_data;
    s_read_setup ##0 ipr_word[`SDEC_B_PEND_BIT] |=> prdata[`SDEC_B_PEND_BIT] && !b_if.valid
                                                   && prdata[`SDEC_B_RSN_LSB +: 4] == $past(b_if.rec_reason);
  endproperty
  a_read_data: assert property (p_read_data) else $error("slot B read data wrong");

  property p_no_rsvd_port;
    a_if.valid |-> a_if.rec_port != `SDEC_PORT_RSVD && (!b_if.valid || b_if.rec_port != `SDEC_PORT_RSVD);
  endproperty
  a_no_rsvd_port: assert property (p_no_rsvd_port) else $error("reserved port recorded");

  property p_irq_pending;
    (!imr_q && (a_if.valid || b_if.valid)) |-> irq;
  endproperty
  a_irq_pending: assert property (p_irq_pending) else $error("irq missing while pending");

  property p_port_field;
    s_read_setup ##0 a_if.valid |=> prdata[`SDEC_A_PORT_LSB +: 2] == $past(a_if.rec_port)
                                   && prdata[`SDEC_A_RSN_LSB +: 4] == $past(a_if.rec_reason);
  endproperty
  a_port_field: assert property (p_port_field) else $error("slot A fields misplaced");

endmodule

// ### tb/tb_switch_drop_event_capture.sv
// self-checking bench of the drop event capture block
`timescale 1ns/1ps
`include "sdec_cfg.svh"
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("BAD %s exp %h got %h", nm, ex, got); end end
module tb_switch_drop_event_capture;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;  // bus and irq
  logic [17:0] paddr;        // byte address
  logic [31:0] pwdata;       // write data
  logic [31:0] prdata;       // read data
  logic [31:0] rdata;        // last word read
  logic        err;          // last error response
  logic        drop_valid;   // event strobe
  logic [3:0]  drop_reason;  // event reason
  logic [1:0]  drop_port;    // event port
  logic        a_v, b_v;     // expected slot flags
  logic [3:0]  a_r, b_r;     // expected reasons
  logic [1:0]  a_p, b_p;     // expected ports
  logic [2:0]  evs_m;        // expected event status
  logic        mask_m;       // expected mask bit
  logic [2:0]  evm_m;        // expected event mask
  logic [31:0] rnd;          // lfsr state
  int          n_mismatch, checks, k;
  localparam logic [17:0] A_IMR = {`SDEC_IMR_IDX, 2'h0};  // mask
  localparam logic [17:0] A_IPR = {`SDEC_IPR_IDX, 2'h0};  // pending
  localparam logic [17:0] A_EVS = {`SDEC_EVS_IDX, 2'h0};  // event status
  localparam logic [17:0] A_EVM = {`SDEC_EVM_IDX, 2'h0};  // event mask
  localparam logic [17:0] A_BAD = {16'h1C24, 2'h0};       // unmapped

  sdec_capture i_sdec_capture (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .drop_valid(drop_valid), .drop_reason(drop_reason),
    .drop_port(drop_port), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////////
  // clock, 50 ns period
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // galois lfsr step
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
  endfunction

  // expected pending word from the slot model
  function automatic logic [31:0] pend_word(input logic av, input logic [3:0] ar, input logic [1:0] ap,
                                            input logic bv, input logic [3:0] br, input logic [1:0] bp);
    pend_word = {18'h0, br, bp, bv, ar, ap, av};
  endfunction

  // expected interrupt level from the model
  function automatic logic irq_exp();
    irq_exp = ~mask_m & (a_v | b_v | (|(evs_m & ~evm_m)));
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // ends once pready reads high; the watchdog stops a stuck wait
    do begin @(posedge pclk); end while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // one drop event, strobe held for back to back calls
  task automatic ev(input logic [3:0] r, input logic [1:0] p);
    @(posedge pclk);
    drop_valid <= 1'b1; drop_reason <= r; drop_port <= p;
    if (p != 2'h3) begin
      if (!a_v) begin a_v = 1'b1; a_r = r; a_p = p; evs_m[0] = 1'b1; end    // slot a first
      else if (!b_v) begin b_v = 1'b1; b_r = r; b_p = p; evs_m[1] = 1'b1; end  // then slot b
      else evs_m[2] = 1'b1;                                                  // both full: lost
    end
  endtask

  // end the strobe, then look at irq once it settled
  task automatic ev_end;
    @(posedge pclk);
    drop_valid <= 1'b0;
    @(negedge pclk);
    `CHK("irq", irq_exp(), irq)
  endtask

  // read pending, compare, model the clear
  task automatic rd_pend;
    apb(1'b0, A_IPR, 32'h0);
    `CHK("pending", pend_word(a_v, a_r, a_p, b_v, b_r, b_p), rdata)
    {a_v, a_r, a_p, b_v, b_r, b_p} = '0;
    `CHK("irq after read", irq_exp(), irq)
  endtask

  // mask write with model update
  task automatic set_mask(input logic m);
    apb(1'b1, A_IMR, {31'h0, m});
    mask_m = m;
  endtask

  // verdict and end of run
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    repeat (30000) @(posedge pclk);
    n_mismatch++;
    $display("timeout");
    wrap_up;
  end

  // main sequence
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    drop_valid = 1'b0; drop_reason = '0; drop_port = '0;
    {a_v, a_r, a_p, b_v, b_r, b_p} = '0;
    evs_m = 3'h0; evm_m = 3'h7; mask_m = 1'b1; n_mismatch = 0; checks = 0; rnd = 32'hF9D9D84B;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // reset values
    apb(1'b0, A_IMR, 32'h0); `CHK("mask rst", 32'h1, rdata)
    `CHK("mask err", 1'b0, err)
    apb(1'b0, A_IPR, 32'h0); `CHK("pend rst", 32'h0, rdata)
    apb(1'b0, A_EVS, 32'h0); `CHK("evs rst", 32'h0, rdata)
    apb(1'b0, A_EVM, 32'h0); `CHK("evm rst", 32'h7, rdata)
    $display("test reset done");
    // masked event still recorded, irq stays low
    ev(sdec_pkg::SDEC_RSN_DROP_LEVEL, sdec_pkg::SDEC_PORT2); ev_end;
    rd_pend;
    $display("test masked done");
    // every reason code, into slot a, unmasked
    set_mask(1'b0);
    for (k = 0; k < 16; k++) begin
      ev(k[3:0], 2'(k % 3)); ev_end;
      rd_pend;
    end
    $display("test reasons done");
    // reserved port code is never recorded
    ev(4'h2, 2'h3); ev_end;
    rd_pend;
    $display("test port done");
    // random bursts of one to three events
    apb(1'b1, A_EVS, 32'h7); evs_m = 3'h0;
    for (k = 0; k < 40; k++) begin
      rnd = lfsr(rnd);
      set_mask(rnd[0]);
      ev(rnd[7:4], 2'(rnd[15:8] % 3));
      if (rnd[2:1] != 2'h0) ev(rnd[19:16], 2'(rnd[27:20] % 3));
      if (rnd[2:1] == 2'h3) ev(rnd[31:28], 2'(rnd[11:8] % 3));
      ev_end;
      rd_pend;
      apb(1'b0, A_EVS, 32'h0); `CHK("evs", {29'h0, evs_m}, rdata)
      apb(1'b1, A_EVS, 32'h7); evs_m = 3'h0;
    end
    $display("test random done");
    // lost-event status reaches irq once its event mask bit is open
    set_mask(1'b0);
    apb(1'b1, A_EVM, 32'h3); evm_m = 3'h3;
    apb(1'b0, A_EVM, 32'h0); `CHK("evm", 32'h3, rdata)
    ev(4'h0, 2'h0); ev(4'h1, 2'h1); ev(4'h2, 2'h2); ev_end;
    rd_pend;
    apb(1'b1, A_EVS, 32'h7); evs_m = 3'h0;
    apb(1'b0, A_EVS, 32'h0); `CHK("evs clr", 32'h0, rdata)
    `CHK("irq evs clr", irq_exp(), irq)
    $display("test event mask done");
    // reset in mid-run brings the mask back up and empties the slots
    ev(4'h5, 2'h0); ev_end;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK("irq in rst", 1'b0, irq)
    presetn <= 1'b1;
    {a_v, a_r, a_p, b_v, b_r, b_p} = '0;
    evs_m = 3'h0; evm_m = 3'h7; mask_m = 1'b1;
    apb(1'b0, A_IMR, 32'h0); `CHK("mask rst2", 32'h1, rdata)
    rd_pend;
    $display("test mid reset done");
    // refused accesses: a write must not disturb a held record
    ev(4'h3, 2'h1); ev_end;
    apb(1'b1, A_IPR, 32'hFFFFFFFF);
    apb(1'b0, A_IPR, 32'h0); `CHK("pend ro", pend_word(1'b1, 4'h3, 2'h1, 1'b0, 4'h0, 2'h0), rdata)
    {a_v, a_r, a_p, b_v, b_r, b_p} = '0;
    apb(1'b0, A_BAD, 32'h0); `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0, rdata)
    $display("test refusal done");
    wrap_up;
  end
endmodule
